// ==== src/wbm_regs.sv ====
// module: watchdog configuration and bus mode register bank reached over the 16-bit spi
`timescale 1ns/10ps
module wbm_regs (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire wbm_pkg::wbm_spi_pins_s spi_pins,
  output logic                        miso_out,
  output logic                        miso_oe,
  input  wire wbm_pkg::wbm_mode_e     sbc_mode,
  input  wire logic                   soft_reset_req,
  input  wire logic                   system_error_flag,
  input  wire logic                   wdog_stop_disable_hi,
  output wbm_pkg::wbm_wdog_s          wdog_config,
  output wbm_pkg::wbm_bus_a_s         bus_mode_control_a,
  output wbm_pkg::wbm_bus_b_s         bus_mode_control_b,
  output logic                        wdog_parity_ok,
  output logic                        wdog_stop_disable,
  output logic                        spi_fail,
  output logic                        wake_ctrl_force
);
  import wbm_pkg::*;

  typedef struct packed {
    wbm_wdog_s  wd;
    wbm_bus_a_s bus_a;
    wbm_bus_b_s bus_b;
    logic [5:0] mode_prev;
    logic       parity_ok;
    logic       stop_dis;
    logic       fail;
    logic       wake_force;
  } wbm_regs_state_s;

  wbm_regs_state_s s;
  wbm_regs_state_s next_s;
  wbm_frame_s      frame;
  logic [6:0]      rd_addr;
  logic [7:0]      rd_data;
  logic            frame_done;
  logic            frame_ok;
  logic            wr_commit;
  logic            sleep_entry;
  logic            stop_entry;
  logic            restart_entry;
  logic            failsafe_entry;
  logic            peak_writable;
  wbm_wdog_s       wd_w;
  wbm_bus_b_s      bus_b_w;

  wbm_spi_frame u_spi (
    .clk        (clk),
    .rst_n      (rst_n),
    .pins       (spi_pins),
    .rd_data    (rd_data),
    .frame      (frame),
    .rd_addr    (rd_addr),
    .frame_done (frame_done),
    .frame_ok   (frame_ok),
    .miso_out   (miso_out),
    .miso_oe    (miso_oe)
  );

  // read mux; reserved bits are held at zero in storage, unmapped reads give zero
  always_comb begin
    if (rd_addr == WBM_ADDR_WDOG) begin
      rd_data = s.wd;
    end else if (rd_addr == WBM_ADDR_BUS_A) begin
      rd_data = s.bus_a;
    end else if (rd_addr == WBM_ADDR_BUS_B) begin
      rd_data = s.bus_b;
    end else begin
      rd_data = 8'h00;
    end
  end

  // mode entries are seen as the first cycle in a new mode
  assign sleep_entry    = (sbc_mode == WBM_MODE_SLEEP) && (s.mode_prev != WBM_MODE_SLEEP);
  assign stop_entry     = (sbc_mode == WBM_MODE_STOP) && (s.mode_prev != WBM_MODE_STOP);
  assign restart_entry  = (sbc_mode == WBM_MODE_RESTART) && (s.mode_prev != WBM_MODE_RESTART);
  assign failsafe_entry = (sbc_mode == WBM_MODE_FAILSAFE) && (s.mode_prev != WBM_MODE_FAILSAFE);
  assign peak_writable  = (sbc_mode == WBM_MODE_INIT) || (sbc_mode == WBM_MODE_NORMAL); // [R19]
  assign wr_commit      = frame_done && frame_ok && frame.write;

  always_comb begin
    next_s = s;
    next_s.fail       = 1'b0;
    next_s.wake_force = 1'b0;
    next_s.mode_prev  = sbc_mode;
    wd_w    = wbm_wdog_s'(frame.data);
    bus_b_w = wbm_bus_b_s'(frame.data & WBM_BUS_B_WMASK); // [R7]
    wd_w.reserved = 1'b0; // [R7]
    // refused period codes leave the running period untouched
    if (wd_w.period_select == WBM_PER_UNLISTED || wd_w.period_select == WBM_PER_RSVD) begin
      wd_w.period_select = s.wd.period_select; // [R23] [R5]
    end
    // a stop-mode attempt on the peak bit is dropped without flagging a failure
    if (!peak_writable) begin
      bus_b_w.main_supply_peak_threshold = s.bus_b.main_supply_peak_threshold; // [R19]
    end
    if (frame_done && !frame_ok) begin
      next_s.fail = 1'b1;
    end else if (wr_commit) begin
      if (frame.addr == WBM_ADDR_WDOG) begin
        // parity, stop disable, type and bus-wake start are stored as written
        next_s.wd = wd_w; // [R1] [R2] [R3] [R4]
      end else if (frame.addr == WBM_ADDR_BUS_A) begin
        next_s.bus_a = wbm_bus_a_s'(frame.data); // [R8] [R9] [R10] [R11] [R12] [R13]
      end else if (frame.addr == WBM_ADDR_BUS_B) begin
        next_s.bus_b = bus_b_w; // [R18] [R20]
      end
    end
    // mode events are applied after the write so they win a same-cycle collision
    if (sleep_entry && !system_error_flag && next_s.bus_a.can_mode[1]) begin
      next_s.bus_a.can_mode = WBM_XCVR_WAKE; // [R15] [R14]
    end
    if (stop_entry) begin
      next_s.bus_a = next_s.bus_a; // [R16]
    end
    if (restart_entry) begin
      next_s.wd = wbm_wdog_s'((next_s.wd & WBM_WD_RESTART_KEEP) | {5'h00, WBM_WD_RESTART_PER}); // [R6]
    end
    if (failsafe_entry) begin
      // forced wake configuration deliberately overrides the selective wake bit
      next_s.bus_a      = wbm_bus_a_s'((next_s.bus_a & WBM_FS_BUS_A_KEEP) | WBM_FS_BUS_A_SET); // [R17]
      next_s.wake_force = 1'b1; // [R17]
    end
    if (soft_reset_req) begin
      next_s.wd    = wbm_wdog_s'(WBM_RST_WDOG); // [R6]
      next_s.bus_a = wbm_bus_a_s'(WBM_RST_BUS_A); // [R21]
      next_s.bus_b = wbm_bus_b_s'(WBM_RST_BUS_B); // [R21]
    end
    next_s.parity_ok = ~(^next_s.wd); // [R1]
    // the other half lives in the internal wake register; either half disables
    next_s.stop_dis = next_s.wd.stop_disable_lo | wdog_stop_disable_hi; // [R22] [R2]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{wd: wbm_wdog_s'(WBM_RST_WDOG), bus_a: wbm_bus_a_s'(WBM_RST_BUS_A),
             bus_b: wbm_bus_b_s'(WBM_RST_BUS_B), mode_prev: 6'h01, parity_ok: 1'b1,
             stop_dis: 1'b0, fail: 1'b0, wake_force: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign wdog_config        = s.wd;
  assign bus_mode_control_a = s.bus_a;
  assign bus_mode_control_b = s.bus_b;
  assign wdog_parity_ok     = s.parity_ok;
  assign wdog_stop_disable  = s.stop_dis;
  assign spi_fail           = s.fail;
  assign wake_ctrl_force    = s.wake_force;

  // checks on the register behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_sleep_to_wake;
    sleep_entry && !system_error_flag && !failsafe_entry && !soft_reset_req
      && ((wr_commit && frame.addr == WBM_ADDR_BUS_A) ? frame.data[1] : s.bus_a.can_mode[1]);
  endsequence

  sequence seq_quiet_a;
    !(wr_commit && frame.addr == WBM_ADDR_BUS_A) && !soft_reset_req;
  endsequence

  sequence seq_stop_peak_write;
    wr_commit && frame.addr == WBM_ADDR_BUS_B && sbc_mode == WBM_MODE_STOP && !soft_reset_req;
  endsequence

  a_wd_reserved_zero: assert property (wdog_config.reserved == 1'b0) // [R7]
    else $error("watchdog reserved bit not zero");

  a_busb_reserved_zero: assert property ((8'(bus_mode_control_b) & ~WBM_BUS_B_WMASK) == 8'h00) // [R7]
    else $error("second bus register reserved bits not zero");

  a_parity_matches: assert property (wdog_parity_ok == ~(^wdog_config)) // [R1]
    else $error("parity flag disagrees with watchdog byte");

  a_period_legal: assert property (wdog_config.period_select != WBM_PER_UNLISTED // [R23]
                                   && wdog_config.period_select != WBM_PER_RSVD)
    else $error("illegal watchdog period stored");

  a_restart_loads: assert property (restart_entry && !soft_reset_req |=> // [R6]
      wdog_config.period_select == WBM_PER_200MS && !wdog_config.stop_disable_lo
      && wdog_config.type_select == $past(next_s.wd.type_select))
    else $error("restart did not load watchdog restart value");

  a_sleep_can_wake: assert property (seq_sleep_to_wake |=> // [R15]
      bus_mode_control_a.can_mode == WBM_XCVR_WAKE
      // sleep keeps whatever selective wake value a same-cycle write leaves behind
      && bus_mode_control_a.selective_wake
         == $past((wr_commit && frame.addr == WBM_ADDR_BUS_A) ? frame.data[2] : s.bus_a.selective_wake))
    else $error("sleep entry did not set can wake capable");

  a_selwake_device: assert property (seq_quiet_a and !failsafe_entry |=> // [R14]
      $stable(bus_mode_control_a.selective_wake))
    else $error("selective wake changed without host write");

  a_stop_keeps_can: assert property (stop_entry ##0 seq_quiet_a and !failsafe_entry |=> // [R16]
      $stable(bus_mode_control_a.can_mode))
    else $error("stop entry changed can mode");

  a_stop_peak_ro: assert property (seq_stop_peak_write |=> // [R19]
      $stable(bus_mode_control_b.main_supply_peak_threshold) && !spi_fail)
    else $error("peak threshold changed or failure flagged in stop mode");

  a_failsafe_force: assert property (failsafe_entry && !soft_reset_req |=> // [R17]
      (8'(bus_mode_control_a) & ~WBM_FS_BUS_A_KEEP) == WBM_FS_BUS_A_SET && wake_ctrl_force ##1 !wake_ctrl_force)
    else $error("fail-safe entry did not force wake configuration");

  a_soft_reset_vals: assert property (soft_reset_req |=> 8'(wdog_config) == WBM_RST_WDOG // [R21]
      && 8'(bus_mode_control_a) == WBM_RST_BUS_A && 8'(bus_mode_control_b) == WBM_RST_BUS_B)
    else $error("soft reset values wrong");

  a_commit_on_cs: assert property (wr_commit && frame.addr == WBM_ADDR_BUS_A && !sleep_entry // [R10]
      && !failsafe_entry && !soft_reset_req |=> 8'(bus_mode_control_a) == $past(frame.data))
    else $error("bus register not updated at chip select rise");

  a_stop_dis_combine: assert property (##1 wdog_stop_disable == // [R22]
      (wdog_config.stop_disable_lo | $past(wdog_stop_disable_hi)))
    else $error("combined stop disable wrong");

endmodule : wbm_regs

// ==== inc/wbm_pkg.sv ====
// package: constants, field layouts and carriers for the watchdog and bus mode register bank
// Overview of operation
// R1: Host sets bit 7 so the whole watchdog byte has even parity; device checks it.
// R2: Watchdog bit 6 set disables the watchdog in Stop mode, clear keeps it active.
// R3: Watchdog bit 5 picks time-out (0) or window (1) watchdog.
// R4: Watchdog bit 4 set lets a bus wake in Stop start the watchdog, open window.
// R5: Period field codes 000..101 select 10, 20, 50, 100, 200, 500 ms; 111 reserved.
// R6: POR or soft reset loads 0x14; restart clears bits 6 and 3, period 100; the code loads period 200 ms.
// R7: Reserved bits read zero: watchdog bit 3, second bus register bits 7:6 and 4:2.
// R8: First bus register bit 7 set turns LIN slope control off for fast flashing.
// R9: First bus register bit 6 set selects LIN low-slope mode for 10.4 kBaud.
// R10: Slope and flash bit changes take effect as chip select rises.
// R11: First bus register bit 5 enables LIN transmit data time-out supervision.
// R12: First LIN mode field 4:3: off, wake capable, receive only, normal; device may update.
// R13: CAN field 2:0: low bits off/wake/receive/normal, bit 2 adds selective wake.
// R14: Device never changes the selective wake bit; only its two lower CAN bits. The code clears it on Fail-Safe entry.
// R15: Sleep entry with no system error turns CAN x11 or x10 into x01.
// R16: Stop entry keeps CAN receive only; wake capable or off stays unchanged.
// R17: Fail-Safe entry forces first bus register to xxx0 1001, wake control to x0x0 0111.
// R18: Second bus register bit 5 selects low (0) or high (1) regulator peak threshold.
// R19: Peak threshold writable in Init and Normal only; Stop writes ignored silently.
// R20: Second LIN mode field 1:0: off, wake capable, receive only, normal.
// R21: After POR or soft reset the bus registers read 0x20 and 0x00.
// R22: A second stop-mode disable bit elsewhere combines with bit 6 into one setting.
// R23: Period codes 110 and 111 from the host are refused; old period stays.
package wbm_pkg;

  localparam logic [6:0] WBM_ADDR_WDOG  = 7'h03;
  localparam logic [6:0] WBM_ADDR_BUS_A = 7'h04;
  localparam logic [6:0] WBM_ADDR_BUS_B = 7'h05;

  localparam logic [7:0] WBM_RST_WDOG  = 8'h14;
  localparam logic [7:0] WBM_RST_BUS_A = 8'h20;
  localparam logic [7:0] WBM_RST_BUS_B = 8'h00;

  localparam logic [7:0] WBM_WD_RESTART_KEEP = 8'hB0;
  localparam logic [2:0] WBM_WD_RESTART_PER  = 3'h4;
  localparam logic [7:0] WBM_BUS_B_WMASK     = 8'h23;
  localparam logic [7:0] WBM_FS_BUS_A_KEEP   = 8'hE0;
  localparam logic [7:0] WBM_FS_BUS_A_SET    = 8'h09;

  localparam logic [2:0] WBM_PER_10MS     = 3'h0;
  localparam logic [2:0] WBM_PER_20MS     = 3'h1;
  localparam logic [2:0] WBM_PER_50MS     = 3'h2;
  localparam logic [2:0] WBM_PER_100MS    = 3'h3;
  localparam logic [2:0] WBM_PER_200MS    = 3'h4;
  localparam logic [2:0] WBM_PER_500MS    = 3'h5;
  localparam logic [2:0] WBM_PER_UNLISTED = 3'h6;
  localparam logic [2:0] WBM_PER_RSVD     = 3'h7;

  localparam logic [1:0] WBM_XCVR_OFF    = 2'h0;
  localparam logic [1:0] WBM_XCVR_WAKE   = 2'h1;
  localparam logic [1:0] WBM_XCVR_RXONLY = 2'h2;
  localparam logic [1:0] WBM_XCVR_NORMAL = 2'h3;

  localparam logic [4:0] WBM_FRAME_BITS = 5'h10;
  localparam logic [4:0] WBM_HEAD_BITS  = 5'h08;
  localparam logic [4:0] WBM_COUNT_MAX  = 5'h11;

  typedef enum logic [5:0] {
    WBM_MODE_INIT     = 6'h01,
    WBM_MODE_NORMAL   = 6'h02,
    WBM_MODE_SLEEP    = 6'h04,
    WBM_MODE_STOP     = 6'h08,
    WBM_MODE_RESTART  = 6'h10,
    WBM_MODE_FAILSAFE = 6'h20
  } wbm_mode_e;

  typedef struct packed {
    logic       parity;
    logic       stop_disable_lo;
    logic       type_select;
    logic       start_on_bus_wake;
    logic       reserved;
    logic [2:0] period_select;
  } wbm_wdog_s;

  typedef struct packed {
    logic       lin_flash;
    logic       lin_low_slope_select;
    logic       lin_tx_timeout_enable;
    logic [1:0] first_lin_channel_mode;
    logic       selective_wake;
    logic [1:0] can_mode;
  } wbm_bus_a_s;

  typedef struct packed {
    logic [1:0] reserved_hi;
    logic       main_supply_peak_threshold;
    logic [2:0] reserved_lo;
    logic [1:0] second_lin_channel_mode;
  } wbm_bus_b_s;

  typedef struct packed {
    logic sclk;
    logic chip_select_n;
    logic mosi;
  } wbm_spi_pins_s;

  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } wbm_frame_s;

endpackage : wbm_pkg

// ==== src/wbm_spi_frame.sv ====
// module: 16-bit spi slave frame receiver with pin synchronisers and read-back shifter
`timescale 1ns/10ps
module wbm_spi_frame (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire wbm_pkg::wbm_spi_pins_s pins,
  input  wire logic [7:0]             rd_data,
  output wbm_pkg::wbm_frame_s         frame,
  output logic [6:0]                  rd_addr,
  output logic                        frame_done,
  output logic                        frame_ok,
  output logic                        miso_out,
  output logic                        miso_oe
);
  import wbm_pkg::*;

  typedef struct packed {
    logic [2:0]  sclk_sy;
    logic [2:0]  cs_sy;
    logic [2:0]  mosi_sy;
    logic        sclk_f;
    logic        cs_f;
    logic        mosi_f;
    logic [15:0] shift;
    logic [4:0]  count;
    logic [7:0]  tx;
    logic [6:0]  addr;
    logic        miso;
    logic        oe;
    logic        done;
    logic        ok;
  } wbm_spi_state_s;

  wbm_spi_state_s s;
  wbm_spi_state_s next_s;
  logic           sclk_nf;
  logic           cs_nf;
  logic           mosi_nf;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    // stage 0 is read only by stage 1; filters look at stages 1 and 2
    next_s.sclk_sy = {s.sclk_sy[1:0], pins.sclk};
    next_s.cs_sy   = {s.cs_sy[1:0], pins.chip_select_n};
    next_s.mosi_sy = {s.mosi_sy[1:0], pins.mosi};
    sclk_nf = (s.sclk_sy[1] == s.sclk_sy[2]) ? s.sclk_sy[2] : s.sclk_f;
    cs_nf   = (s.cs_sy[1] == s.cs_sy[2]) ? s.cs_sy[2] : s.cs_f;
    mosi_nf = (s.mosi_sy[1] == s.mosi_sy[2]) ? s.mosi_sy[2] : s.mosi_f;
    next_s.sclk_f = sclk_nf;
    next_s.cs_f   = cs_nf;
    next_s.mosi_f = mosi_nf;
    next_s.oe     = ~cs_nf;
    if (s.cs_f && !cs_nf) begin
      next_s.count = 5'h00;
      next_s.tx    = 8'h00;
      next_s.miso  = 1'b0;
    end else if (!s.cs_f && cs_nf) begin
      // the frame is committed only as chip select returns high
      next_s.done = 1'b1; // [R10]
      next_s.ok   = (s.count == WBM_FRAME_BITS);
      next_s.miso = 1'b0;
    end else if (!s.cs_f) begin
      if (sclk_nf && !s.sclk_f) begin
        next_s.shift = {s.shift[14:0], s.mosi_f};
        if (s.count != WBM_COUNT_MAX) begin
          next_s.count = s.count + 5'h01;
        end
        if (s.count == WBM_HEAD_BITS - 5'h01) begin
          next_s.addr = {s.shift[5:0], s.mosi_f};
        end
      end else if (!sclk_nf && s.sclk_f) begin
        // read-back shows the stored value, never the byte being written
        if (s.count == WBM_HEAD_BITS) begin
          next_s.miso = rd_data[7];
          next_s.tx   = {rd_data[6:0], 1'b0};
        end else begin
          next_s.miso = s.tx[7];
          next_s.tx   = {s.tx[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{sclk_sy: 3'h0, cs_sy: 3'h7, mosi_sy: 3'h0, sclk_f: 1'b0, cs_f: 1'b1, mosi_f: 1'b0,
             shift: 16'h0000, count: 5'h00, tx: 8'h00, addr: 7'h00, miso: 1'b0, oe: 1'b0,
             done: 1'b0, ok: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign frame      = wbm_frame_s'(s.shift);
  assign rd_addr    = s.addr;
  assign frame_done = s.done;
  assign frame_ok   = s.ok;
  assign miso_out   = s.miso;
  assign miso_oe    = s.oe;

endmodule : wbm_spi_frame

// ==== verification/wbm_spi_host.sv ====
// host microcontroller model: 16-bit spi master in mode 0, msb first
`timescale 1ns/10ps
module wbm_spi_host (
  input  wire logic              clk,
  input  wire logic              miso_out,
  output wbm_pkg::wbm_spi_pins_s pins
);
  import wbm_pkg::*;
  // half sclk period in clk cycles; the pin filter needs at least 4
  localparam int HALF = 10;

  initial pins = '{sclk: 1'b0, chip_select_n: 1'b1, mosi: 1'b0};

  // nbits other than 16 only when a scenario wants a length error
  task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clk);
    pins.chip_select_n = 1'b0;
    repeat (HALF) @(negedge clk);
    for (int i = 0; i < nbits; i++) begin
      pins.mosi = word[15 - i];
      repeat (HALF) @(negedge clk);
      rx = {rx[6:0], miso_out};
      pins.sclk = 1'b1;
      repeat (HALF) @(negedge clk);
      pins.sclk = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    pins.chip_select_n = 1'b1;
    // released data line must not keep showing the last bit
    pins.mosi = ~pins.mosi;
    // commit lands about 5 clk after chip select rises; 12 bounds it
    repeat (12) @(negedge clk);
  endtask : frame
endmodule : wbm_spi_host

// ==== verification/tb_top.sv ====
// self-checking bench for the watchdog and bus mode register bank
`timescale 1ns/10ps
module tb_top;
  import wbm_pkg::*;
  logic          clk, rst_n, soft_reset_req, system_error_flag, wdog_stop_disable_hi;
  logic          miso_out, miso_oe, wdog_parity_ok, wdog_stop_disable, spi_fail, wake_ctrl_force;
  wbm_mode_e     sbc_mode;
  wbm_spi_pins_s spi_pins;
  wbm_wdog_s     wdog_config;
  wbm_bus_a_s    bus_mode_control_a;
  wbm_bus_b_s    bus_mode_control_b;
  int            err_total, n_compared, fail_seen, force_seen, oe_seen;
  logic [7:0]    rx;

  wbm_regs wbm_regs_inst (.clk(clk), .rst_n(rst_n), .spi_pins(spi_pins), .miso_out(miso_out),
    .miso_oe(miso_oe), .sbc_mode(sbc_mode), .soft_reset_req(soft_reset_req),
    .system_error_flag(system_error_flag), .wdog_stop_disable_hi(wdog_stop_disable_hi),
    .wdog_config(wdog_config), .bus_mode_control_a(bus_mode_control_a),
    .bus_mode_control_b(bus_mode_control_b), .wdog_parity_ok(wdog_parity_ok),
    .wdog_stop_disable(wdog_stop_disable), .spi_fail(spi_fail), .wake_ctrl_force(wake_ctrl_force));
  wbm_spi_host wbm_spi_host_inst (.clk(clk), .miso_out(miso_out), .pins(spi_pins));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // pulses and enable cycles are counted on the falling clk edge so scenarios can compare totals
  always @(negedge clk) begin
    if (spi_fail === 1'b1) fail_seen++;
    if (wake_ctrl_force === 1'b1) force_seen++;
    if (miso_oe === 1'b1) oe_seen++;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  function automatic logic [7:0] par(input logic [6:0] low7);
    return {^low7, low7};
  endfunction : par

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    wbm_spi_host_inst.frame({1'b1, a, d}, 16, rx);
  endtask : wr

  task automatic rd(input logic [6:0] a);
    wbm_spi_host_inst.frame({1'b0, a, 8'h00}, 16, rx);
  endtask : rd

  task automatic go(input wbm_mode_e m);
    @(negedge clk);
    sbc_mode = m;
    repeat (3) @(negedge clk);
  endtask : go

  task automatic t_reset();
    chk("wdog_por", wdog_config, 8'h14);
    chk("bus_a_por", bus_mode_control_a, 8'h20);
    chk("bus_b_por", bus_mode_control_b, 8'h00);
    chk("parity_por", {7'h00, wdog_parity_ok}, 8'h01);
    chk("oe_idle", {7'h00, miso_oe}, 8'h00);
  endtask : t_reset

  task automatic t_wdog();
    logic [2:0] per;
    int         o0;
    o0 = oe_seen;
    wr(WBM_ADDR_WDOG, par(7'h75));
    // chip select is low for 340 clk per 16-bit frame; the enable follows it with equal delay on both edges
    chk("oe_frame", {7'h00, (oe_seen - o0) == 340}, 8'h01);
    chk("wdog_wr", wdog_config, 8'hF5);
    chk("parity_ok", {7'h00, wdog_parity_ok}, 8'h01);
    chk("stop_dis_lo", {7'h00, wdog_stop_disable}, 8'h01);
    rd(WBM_ADDR_WDOG);
    chk("wdog_rd", rx, 8'hF5);
    wr(WBM_ADDR_WDOG, 8'h04);
    chk("parity_bad", {7'h00, wdog_parity_ok}, 8'h00);
    chk("stop_dis_off", {7'h00, wdog_stop_disable}, 8'h00);
    @(negedge clk);
    wdog_stop_disable_hi = 1'b1;
    repeat (3) @(negedge clk);
    chk("stop_dis_hi", {7'h00, wdog_stop_disable}, 8'h01);
    wdog_stop_disable_hi = 1'b0;
    per = 3'h4;
    // reserved bit 3 is set in every write and must never stick
    for (int p = 0; p < 8; p++) begin
      wr(WBM_ADDR_WDOG, par({4'b0001, p[2:0]}));
      if (p < 6) per = p[2:0];
      chk("wdog_period", wdog_config, {^{1'b1, p[2:0]}, 4'b0000, per});
    end
  endtask : t_wdog

  task automatic t_bus_a();
    logic [7:0] d, prev;
    go(WBM_MODE_NORMAL);
    prev = bus_mode_control_a;
    for (int i = 0; i < 8; i++) begin
      d = {i[0], i[1], i[2], i[1:0], i[2:0]};
      wr(WBM_ADDR_BUS_A, d);
      chk("bus_a_old", rx, prev);
      chk("bus_a_wr", bus_mode_control_a, d);
      prev = d;
    end
    rd(WBM_ADDR_BUS_A);
    chk("bus_a_rd", rx, prev);
    wr(7'h10, 8'hFF);
    rd(7'h10);
    chk("unmapped_rd", rx, 8'h00);
    chk("unmapped_side", bus_mode_control_a, prev);
  endtask : t_bus_a

  task automatic t_bus_b();
    int f0;
    for (int i = 0; i < 4; i++) begin
      wr(WBM_ADDR_BUS_B, {6'h3F, i[1:0]});
      chk("bus_b_wr", bus_mode_control_b, {3'b001, 3'b000, i[1:0]});
    end
    go(WBM_MODE_STOP);
    chk("stop_entry", bus_mode_control_b, 8'h23);
    f0 = fail_seen;
    wr(WBM_ADDR_BUS_B, 8'h02);
    chk("peak_in_stop", bus_mode_control_b, 8'h22);
    chk("no_fail_stop", 8'(fail_seen), 8'(f0));
    go(WBM_MODE_INIT);
    wr(WBM_ADDR_BUS_B, 8'h00);
    chk("peak_in_init", bus_mode_control_b, 8'h00);
  endtask : t_bus_b

  task automatic ev(input logic se, input logic [7:0] pre, input wbm_mode_e m, input logic [7:0] exp);
    go(WBM_MODE_NORMAL);
    system_error_flag = se;
    wr(WBM_ADDR_BUS_A, pre);
    go(m);
    chk("mode_entry", bus_mode_control_a, exp);
    system_error_flag = 1'b0;
  endtask : ev

  task automatic t_modes();
    int f0;
    ev(1'b0, 8'h1B, WBM_MODE_SLEEP, 8'h19);
    ev(1'b0, 8'h1E, WBM_MODE_SLEEP, 8'h1D);
    ev(1'b0, 8'h1F, WBM_MODE_SLEEP, 8'h1D);
    ev(1'b1, 8'h1B, WBM_MODE_SLEEP, 8'h1B);
    ev(1'b0, 8'h1A, WBM_MODE_STOP, 8'h1A);
    ev(1'b0, 8'h19, WBM_MODE_SLEEP, 8'h19);
    ev(1'b0, 8'h04, WBM_MODE_SLEEP, 8'h04);
    go(WBM_MODE_NORMAL);
    wr(WBM_ADDR_WDOG, par(7'h75));
    go(WBM_MODE_RESTART);
    chk("wdog_restart", wdog_config, 8'hB4);
    f0 = force_seen;
    ev(1'b0, 8'hFF, WBM_MODE_FAILSAFE, 8'hE9);
    chk("wake_force", 8'(force_seen), 8'(f0 + 1));
    chk("fs_bus_b", bus_mode_control_b, 8'h00);
  endtask : t_modes

  task automatic t_len_soft();
    int f0;
    go(WBM_MODE_NORMAL);
    wr(WBM_ADDR_BUS_A, 8'h20);
    f0 = fail_seen;
    wbm_spi_host_inst.frame({1'b1, WBM_ADDR_BUS_A, 8'hFF}, 12, rx);
    chk("short_fail", 8'(fail_seen), 8'(f0 + 1));
    chk("short_nowr", bus_mode_control_a, 8'h20);
    wr(WBM_ADDR_BUS_A, 8'hFF);
    wr(WBM_ADDR_WDOG, par(7'h75));
    @(negedge clk);
    soft_reset_req = 1'b1;
    @(negedge clk);
    soft_reset_req = 1'b0;
    repeat (3) @(negedge clk);
    chk("soft_wdog", wdog_config, 8'h14);
    chk("soft_bus_a", bus_mode_control_a, 8'h20);
    chk("soft_bus_b", bus_mode_control_b, 8'h00);
  endtask : t_len_soft

  initial begin
    rst_n = 1'b0;
    soft_reset_req = 1'b0;
    system_error_flag = 1'b0;
    wdog_stop_disable_hi = 1'b0;
    sbc_mode = WBM_MODE_INIT;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_wdog();
    t_bus_a();
    t_bus_b();
    t_modes();
    t_len_soft();
    stop_test();
  end

  // cuts a hang short well inside the cycle budget
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule : tb_top
